// *** design/sscp_cfg.svh ***
// Constants for the sensor serial control port: addresses, bit slots and timing.
`ifndef SSCP_CFG_SVH
`define SSCP_CFG_SVH

// Device address pairs chosen by the address-select pin
`define SSCP_WR_ADDR_SEL0 8'h78
`define SSCP_RD_ADDR_SEL0 8'h79
`define SSCP_WR_ADDR_SEL1 8'h7A
`define SSCP_RD_ADDR_SEL1 8'h7B

// Bit slots inside one nine-clock byte frame
`define SSCP_LAST_BIT 4'h7
`define SSCP_ACK_SLOT 4'h8
`define SSCP_CNT_RESET 4'h0

// Reset value of every internal sensor register and of the address pointer
`define SSCP_REG_RESET 8'h00
`define SSCP_PTR_RESET 8'h00

// Link-side clear after a start or stop, in ns, and the system clock period
`define SSCP_CLEAR_NS 16
`define SSCP_SYS_PERIOD_NS 4
`define SSCP_CLEAR_CYC ((`SSCP_CLEAR_NS + `SSCP_SYS_PERIOD_NS - 1) / `SSCP_SYS_PERIOD_NS)

`endif

// *** design/sscp_pkg.sv ***
// Types shared by the sensor serial control port.
package sscp_pkg;
	typedef enum logic [4:0] {
		ST_ADDR = 5'h01,
		ST_REGA = 5'h02,
		ST_WDATA = 5'h04,
		ST_RDATA = 5'h08,
		ST_IGNORE = 5'h10
	} sscp_state_type;
endpackage

// *** design/sscp_regmem.sv ***
// Internal sensor register file: one write port, registered read port.
`include "sscp_cfg.svh"
module sscp_regmem #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata_r
);
	logic [DW-1:0] mem_r [0:(1<<AW)-1];

	// Flop array so the pin reset returns every register to its default
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < (1<<AW); i++) begin
				mem_r[i] <= DW'(`SSCP_REG_RESET);
			end
		end else if (we) begin
			mem_r[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= DW'(`SSCP_REG_RESET);
		end else begin
			rdata_r <= mem_r[raddr];
		end
	end
endmodule

// *** design/sscp_sync.sv ***
// Two-flop synchroniser for levels entering a clock domain.
module sscp_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

// *** design/sscp_top.sv ***
// Two-wire serial control slave of the image sensor with its register file.
`include "sscp_cfg.svh"

// Function
// - Address bit zero selects write or read
// - Device acknowledges its own address
// - Register address byte follows, device acknowledges
// - Write data bytes each acknowledged by device
// - Device shifts read bytes, master acknowledges
// - Master no-acknowledge ends read data
// - Select low answers 78H and 79H
// - Select high answers 7AH and 7BH
// - Start is data falling while clock high
// - Stop is data rising while clock high
// - Acknowledge holds data low whole high phase
// - Reset pin restores port and registers
module sscp_top
	import sscp_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RSTN,
	input wire logic CONTROL_BUS_CLOCK_PIN,
	input wire logic CONTROL_BUS_DATA_PIN_I,
	output logic CONTROL_BUS_DATA_PIN_O,
	output logic CONTROL_BUS_DATA_PIN_OE,
	input wire logic BUS_ADDRESS_SELECT_PIN,
	output logic BUS_BUSY,
	output logic REG_WR_STROBE,
	output logic [7:0] REG_WR_ADDR,
	output logic [7:0] REG_WR_DATA
);
	// Whole byte against both halves of the pair, so bit zero takes part too
	function automatic logic addr_match(input logic [7:0] b, input logic sel);
		logic [7:0] wr_a;
		logic [7:0] rd_a;
		wr_a = sel ? `SSCP_WR_ADDR_SEL1 : `SSCP_WR_ADDR_SEL0;
		rd_a = sel ? `SSCP_RD_ADDR_SEL1 : `SSCP_RD_ADDR_SEL0;
		return (b == wr_a) || (b == rd_a);
	endfunction

	// ---------------- Link domain, clocked by the master's bus clock
	logic scl;
	logic sda_in;
	logic bus_clear_r;
	logic link_rstn;
	logic sel_s;
	sscp_state_type state_r;
	sscp_state_type state_nxt;
	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;
	logic [7:0] shift_r;
	logic [7:0] shift_nxt;
	logic [7:0] byte_w;
	logic last_bit_w;
	logic ack_slot_w;
	logic match_w;
	logic ack_pend_r;
	logic ack_pend_nxt;
	logic rw_r;
	logic rw_nxt;
	logic [7:0] tx_r;
	logic [7:0] tx_nxt;
	logic load_tx_w;
	logic [7:0] reg_addr_r;
	logic [7:0] reg_addr_nxt;
	logic [7:0] rd_data_w;
	logic mem_we_w;
	logic wr_toggle_r;
	logic [7:0] wr_addr_hold_r;
	logic [7:0] wr_data_hold_r;
	logic drive_low_w;
	logic out_low_r;

	assign scl = CONTROL_BUS_CLOCK_PIN;
	assign sda_in = CONTROL_BUS_DATA_PIN_I;
	// Start or stop clears the link logic; released while the clock is high
	assign link_rstn = RSTN & ~bus_clear_r;

	sscp_sync #(.W(1)) u_sel_sync (
		.clk(scl),
		.rst_n(RSTN),
		.d(BUS_ADDRESS_SELECT_PIN),
		.q(sel_s)
	);

	// Data is sampled on the rising edge, trusting the master to hold it
	assign byte_w = {shift_r[6:0], sda_in};
	assign last_bit_w = (cnt_r == `SSCP_LAST_BIT);
	assign ack_slot_w = (cnt_r == `SSCP_ACK_SLOT);
	assign match_w = addr_match(byte_w, sel_s);
	assign cnt_nxt = ack_slot_w ? `SSCP_CNT_RESET : cnt_r + 4'h1;
	assign shift_nxt = ack_slot_w ? shift_r : byte_w;
	assign ack_pend_nxt = last_bit_w ?
		(((state_r == ST_ADDR) && match_w) || (state_r == ST_REGA) ||
		(state_r == ST_WDATA)) :
		(ack_slot_w ? 1'b0 : ack_pend_r);
	assign rw_nxt = (last_bit_w && (state_r == ST_ADDR)) ? byte_w[0] : rw_r;

	always_comb begin
		state_nxt = state_r;
		if (ack_slot_w) begin
			case (state_r)
				ST_ADDR: begin
					if (!ack_pend_r) begin
						state_nxt = ST_IGNORE;
					end else if (rw_r) begin
						state_nxt = ST_RDATA;
					end else begin
						state_nxt = ST_REGA;
					end
				end
				ST_REGA: begin
					state_nxt = ST_WDATA;
				end
				ST_WDATA: begin
					state_nxt = ST_WDATA;
				end
				ST_RDATA: begin
					// Master no-acknowledge ends the read burst
					state_nxt = sda_in ? ST_IGNORE : ST_RDATA;
				end
				ST_IGNORE: begin
					state_nxt = ST_IGNORE;
				end
				default: begin
					state_nxt = ST_IGNORE;
				end
			endcase
		end
	end

	assign load_tx_w = ack_slot_w && (state_nxt == ST_RDATA);
	assign tx_nxt = load_tx_w ? rd_data_w :
		(((state_r == ST_RDATA) && !ack_slot_w) ? {tx_r[6:0], 1'b1} : tx_r);

	// Pointer survives a repeated start so a read follows the register write
	assign reg_addr_nxt = ((state_r == ST_REGA) && last_bit_w) ? byte_w :
		((ack_slot_w && ((state_r == ST_WDATA) || load_tx_w)) ?
		reg_addr_r + 8'h01 : reg_addr_r);
	assign mem_we_w = (state_r == ST_WDATA) && last_bit_w;

	sscp_regmem #(.AW(8), .DW(8)) u_regmem (
		.clk(scl),
		.rst_n(RSTN),
		.we(mem_we_w),
		.waddr(reg_addr_r),
		.wdata(byte_w),
		.raddr(reg_addr_r),
		.rdata_r(rd_data_w)
	);

	always_ff @(posedge scl or negedge link_rstn) begin
		if (!link_rstn) begin
			state_r <= ST_ADDR;
			cnt_r <= `SSCP_CNT_RESET;
			shift_r <= `SSCP_REG_RESET;
			ack_pend_r <= 1'b0;
			rw_r <= 1'b0;
			tx_r <= `SSCP_REG_RESET;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			shift_r <= shift_nxt;
			ack_pend_r <= ack_pend_nxt;
			rw_r <= rw_nxt;
			tx_r <= tx_nxt;
		end
	end

	// Pin reset only: a toggle cleared by a start would fake a write
	always_ff @(posedge scl or negedge RSTN) begin
		if (!RSTN) begin
			reg_addr_r <= `SSCP_PTR_RESET;
			wr_toggle_r <= 1'b0;
			wr_addr_hold_r <= `SSCP_PTR_RESET;
			wr_data_hold_r <= `SSCP_REG_RESET;
		end else begin
			reg_addr_r <= reg_addr_nxt;
			if (mem_we_w) begin
				wr_toggle_r <= ~wr_toggle_r;
				wr_addr_hold_r <= reg_addr_r;
				wr_data_hold_r <= byte_w;
			end
		end
	end

	// Output changes on the falling edge so it is stable over the high phase
	assign drive_low_w = (ack_slot_w && ack_pend_r) ||
		((state_r == ST_RDATA) && !ack_slot_w && !tx_r[7]);

	always_ff @(negedge scl or negedge link_rstn) begin
		if (!link_rstn) begin
			out_low_r <= 1'b0;
		end else begin
			out_low_r <= drive_low_w;
		end
	end

	assign CONTROL_BUS_DATA_PIN_O = 1'b0;
	assign CONTROL_BUS_DATA_PIN_OE = out_low_r;

	// ---------------- System domain: start and stop watch, write notify
	logic scl_s;
	logic sda_s;
	logic tgl_s;
	logic scl_d_r;
	logic sda_d_r;
	logic tgl_d_r;
	logic start_w;
	logic stop_w;
	logic tgl_edge_w;
	logic [2:0] clear_cnt_r;
	logic [2:0] clear_cnt_nxt;
	logic bus_clear_nxt;
	logic busy_r;
	logic strobe_r;
	logic [7:0] wr_addr_r;
	logic [7:0] wr_data_r;

	sscp_sync #(.W(3)) u_sys_sync (
		.clk(SYS_CLK),
		.rst_n(RSTN),
		.d({scl, sda_in, wr_toggle_r}),
		.q({scl_s, sda_s, tgl_s})
	);

	// Only synchronised copies are compared; raw pins never feed this logic
	assign start_w = scl_s && scl_d_r && sda_d_r && !sda_s;
	assign stop_w = scl_s && scl_d_r && !sda_d_r && sda_s;
	assign tgl_edge_w = tgl_s ^ tgl_d_r;
	assign clear_cnt_nxt = (start_w || stop_w) ? 3'(`SSCP_CLEAR_CYC - 1) :
		((clear_cnt_r != 3'h0) ? clear_cnt_r - 3'h1 : 3'h0);
	assign bus_clear_nxt = start_w || stop_w || (clear_cnt_r != 3'h0);

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			tgl_d_r <= 1'b0;
			clear_cnt_r <= 3'h0;
			bus_clear_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
			tgl_d_r <= tgl_s;
			clear_cnt_r <= clear_cnt_nxt;
			bus_clear_r <= bus_clear_nxt;
			busy_r <= start_w | (busy_r & ~stop_w);
		end
	end

	// Held words are stable for a whole byte time when the toggle lands
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			strobe_r <= 1'b0;
			wr_addr_r <= `SSCP_PTR_RESET;
			wr_data_r <= `SSCP_REG_RESET;
		end else begin
			strobe_r <= tgl_edge_w;
			if (tgl_edge_w) begin
				wr_addr_r <= wr_addr_hold_r;
				wr_data_r <= wr_data_hold_r;
			end
		end
	end

	assign BUS_BUSY = busy_r;
	assign REG_WR_STROBE = strobe_r;
	assign REG_WR_ADDR = wr_addr_r;
	assign REG_WR_DATA = wr_data_r;

	// ---------------- Checks
	a_ack_own_addr: assert property (@(posedge scl) disable iff (!link_rstn)
		(state_r == ST_ADDR && last_bit_w && match_w) |=> (ack_pend_r && out_low_r))
		else $error("own address not acknowledged");
	a_no_ack_other: assert property (@(posedge scl) disable iff (!link_rstn)
		(state_r == ST_ADDR && last_bit_w && !match_w) |=> (!out_low_r ##1 state_r == ST_IGNORE))
		else $error("foreign address acknowledged");
	a_ack_high_phase: assert property (@(posedge scl) disable iff (!link_rstn)
		(ack_slot_w && ack_pend_r) |-> out_low_r)
		else $error("acknowledge not low during clock high");
	a_rw_direction: assert property (@(posedge scl) disable iff (!link_rstn)
		(state_r == ST_ADDR && ack_slot_w && ack_pend_r) |=>
		(state_r == (rw_r ? ST_RDATA : ST_REGA)))
		else $error("direction bit misapplied");
	a_reg_addr_capture: assert property (@(posedge scl) disable iff (!link_rstn)
		(state_r == ST_REGA && last_bit_w) |=> (reg_addr_r == $past(byte_w) && out_low_r))
		else $error("register address not captured or acknowledged");
	a_write_notify: assert property (@(posedge scl) disable iff (!link_rstn)
		(state_r == ST_WDATA && last_bit_w) |=> (wr_toggle_r != $past(wr_toggle_r)) && out_low_r)
		else $error("write byte not stored or acknowledged");
	a_read_bit_out: assert property (@(posedge scl) disable iff (!link_rstn)
		(state_r == ST_RDATA && !ack_slot_w) |-> (out_low_r == !tx_r[7]))
		else $error("read bit not on the data line");
	a_nack_release: assert property (@(posedge scl) disable iff (!link_rstn)
		(state_r == ST_RDATA && ack_slot_w && sda_in) |=> (!out_low_r)[*2])
		else $error("read data continued after no-acknowledge");
	a_idle_release: assert property (@(posedge scl) disable iff (!link_rstn)
		(state_r == ST_IGNORE) |=> !out_low_r)
		else $error("data line held while not addressed");
	a_start_clear: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		start_w |=> bus_clear_r[*4] ##1 busy_r)
		else $error("start did not clear the link logic");
	a_stop_detect: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		stop_w |=> (bus_clear_r && !busy_r))
		else $error("stop not recognised");
	a_strobe_pulse: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		tgl_edge_w |=> (REG_WR_STROBE ##1 !REG_WR_STROBE))
		else $error("write strobe not a single pulse");
	a_reset_state: assert property (@(posedge SYS_CLK)
		$rose(RSTN) |-> (!BUS_BUSY && !REG_WR_STROBE && !CONTROL_BUS_DATA_PIN_OE))
		else $error("outputs not at reset values");
	// Line release after each write acknowledge and around frame edges; pointer step and read load
	a_ack_release: assert property (@(posedge scl) disable iff (!link_rstn)
		(ack_slot_w && ack_pend_r && !rw_r) |=> !out_low_r)
		else $error("data line held after acknowledge");
	a_ptr_step: assert property (@(posedge scl) disable iff (!link_rstn)
		(state_r == ST_WDATA && ack_slot_w) |=> (reg_addr_r == $past(reg_addr_r) + 8'h01))
		else $error("register pointer did not advance");
	a_frame_release: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		(start_w || stop_w) |=> !CONTROL_BUS_DATA_PIN_OE)
		else $error("data line held across start or stop");
	a_read_load: assert property (@(posedge scl) disable iff (!link_rstn)
		(state_r == ST_ADDR && ack_slot_w && ack_pend_r && rw_r) |=> (tx_r == $past(rd_data_w)))
		else $error("read byte not loaded");

	// Main scenarios
	c_write_byte: cover property (@(posedge scl) disable iff (!link_rstn)
		state_r == ST_WDATA && ack_slot_w);
	c_read_nack: cover property (@(posedge scl) disable iff (!link_rstn)
		state_r == ST_RDATA && ack_slot_w && sda_in);
	c_read_ack: cover property (@(posedge scl) disable iff (!link_rstn)
		state_r == ST_RDATA && ack_slot_w && !sda_in);
	c_start_seen: cover property (@(posedge SYS_CLK) disable iff (!RSTN) start_w && busy_r);
	c_foreign_addr: cover property (@(posedge scl) disable iff (!link_rstn)
		state_r == ST_ADDR && last_bit_w && !match_w);
endmodule

// *** test/sscp_master.sv ***
// Two-wire bus master model that drives the control port from the far side.
module sscp_master (
	output logic scl,
	output logic pull,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 10ps;
	localparam realtime HALF = 7.5;
	// Long hold after start/stop so the port's link clear has settled
	localparam realtime HOLD = 45.0;
	initial begin
		scl = 1'b1;
		pull = 1'b0;
	end
	// Data moves only mid low phase, sampled at the rising clock
	task automatic bit_x(input logic b, output logic r);
		#(HALF / 2) pull = ~b;
		#(HALF / 2) scl = 1'b1;
		r = sda;
		#HALF scl = 1'b0;
	endtask
	// Fresh or repeated start; the clock stands high between frames
	task automatic start_c();
		pull = 1'b0;
		#HALF scl = 1'b1;
		#HOLD pull = 1'b1;
		#HOLD scl = 1'b0;
	endtask
	task automatic stop_c();
		pull = 1'b1;
		#HALF scl = 1'b1;
		#HOLD pull = 1'b0;
		#HOLD;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(d[i], r);
		bit_x(1'b1, r);
		ack = ~r;
	endtask
	task automatic rbyte(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, r);
			d[i] = r;
		end
		bit_x(nack, r);
	endtask
endmodule

// *** test/testbench.sv ***
// Self-checking bench for the control port, driven through the bus master model.
module testbench;
	timeunit 1ns;
	timeprecision 10ps;
	logic SYS_CLK = 1'b0;
	// Left unknown so the first drive low is a real falling edge
	logic RSTN;
	logic sel = 1'b0;
	logic scl, pull, oe, sdo, busy, strb;
	logic [7:0] wr_addr, wr_data;
	logic [7:0] mem [256];
	// Open-drain wire with pull-up
	wire logic sda = ~pull & (~oe | sdo);
	int fails = 0;
	int num_checks = 0;
	int nstrb = 0;
	sscp_top dut (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .CONTROL_BUS_CLOCK_PIN(scl),
		.CONTROL_BUS_DATA_PIN_I(sda), .CONTROL_BUS_DATA_PIN_O(sdo),
		.CONTROL_BUS_DATA_PIN_OE(oe), .BUS_ADDRESS_SELECT_PIN(sel), .BUS_BUSY(busy),
		.REG_WR_STROBE(strb), .REG_WR_ADDR(wr_addr), .REG_WR_DATA(wr_data));
	sscp_master m (.scl(scl), .pull(pull), .sda(sda));
	initial begin
		forever #2 SYS_CLK = ~SYS_CLK;
	end
	always @(posedge SYS_CLK) if (strb === 1'b1) nstrb++;
	initial begin
		repeat (100000) @(posedge SYS_CLK);
		fails++;
		summarize();
	end
	function automatic logic [7:0] addr_of(input logic s, input logic rd);
		return (s ? 8'h7A : 8'h78) | {7'h00, rd};
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Select is only changed under reset, as the port expects it static
	task automatic do_reset(input logic s);
		@(posedge SYS_CLK) #1 RSTN = 1'b0;
		sel = s;
		repeat (6) @(posedge SYS_CLK);
		#1 RSTN = 1'b1;
		repeat (3) @(posedge SYS_CLK);
		foreach (mem[i]) mem[i] = 8'h00;
	endtask
	task automatic wr(input logic [7:0] ra, input int n);
		logic a;
		logic [7:0] d;
		nstrb = 0;
		m.start_c();
		chk({7'h00, busy}, 8'h01);
		m.wbyte(addr_of(sel, 1'b0), a);
		chk({7'h00, a}, 8'h01);
		m.wbyte(ra, a);
		chk({7'h00, a}, 8'h01);
		for (int i = 0; i < n; i++) begin
			d = 8'($urandom);
			m.wbyte(d, a);
			chk({7'h00, a}, 8'h01);
			mem[8'(ra + i)] = d;
		end
		m.stop_c();
		#20;
		chk({7'h00, busy}, 8'h00);
		chk(8'(nstrb), 8'(n));
		chk(wr_addr, 8'(ra + n - 1));
		chk(wr_data, d);
	endtask
	task automatic rd(input logic [7:0] ra, input int n);
		logic a;
		logic [7:0] d;
		m.start_c();
		m.wbyte(addr_of(sel, 1'b0), a);
		m.wbyte(ra, a);
		m.start_c();
		m.wbyte(addr_of(sel, 1'b1), a);
		chk({7'h00, a}, 8'h01);
		for (int i = 0; i < n; i++) begin
			m.rbyte(i == n - 1, d);
			chk(d, mem[8'(ra + i)]);
		end
		// Line must stay released after the master's refusal
		m.bit_x(1'b1, a);
		chk({7'h00, a}, 8'h01);
		chk({7'h00, sdo}, 8'h00);
		m.stop_c();
	endtask
	task automatic wrong(input logic rdb);
		logic a;
		m.start_c();
		m.wbyte(addr_of(~sel, rdb), a);
		chk({7'h00, a}, 8'h00);
		m.wbyte(8'h00, a);
		chk({7'h00, a}, 8'h00);
		m.stop_c();
	endtask
	initial begin
		logic [7:0] ra;
		logic a;
		ra = 8'($urandom(32'haa70));
		for (int s = 0; s < 2; s++) begin
			do_reset(s[0]);
			rd(ra, 1);
			for (int k = 0; k < 3; k++) begin
				wr(ra, 2);
				rd(ra, 2);
				ra = 8'($urandom);
			end
			wr(8'hFF, 2);
			rd(8'hFF, 2);
			$display("test write_read sel=%0d done", s);
			wrong(1'b0);
			wrong(1'b1);
			$display("test foreign_address sel=%0d done", s);
			// Half a data byte, then a start: nothing may be written
			m.start_c();
			m.wbyte(addr_of(sel, 1'b0), a);
			m.wbyte(ra, a);
			for (int b = 0; b < 4; b++) m.bit_x(1'b0, a);
			wr(8'(ra + 1), 1);
			rd(ra, 2);
			$display("test restart sel=%0d done", s);
		end
		summarize();
	end
endmodule
